// File: hdl/csd_core_sfr.sv
// Core SFR bank, scratchpad RAM and data-memory decode
`timescale 1ns/1ps
module csd_core_sfr (
	input wire logic clk,
	input wire logic rst_n,
	// Internal RAM / SFR access from the core
	input wire logic iram_rd,
	input wire logic iram_wr,
	input wire logic iram_indirect,
	input wire logic [7:0] iram_addr,
	input wire logic [7:0] iram_wdata,
	input wire logic bit_op,
	input wire logic [2:0] bit_sel,
	input wire logic bit_wval,
	output logic [7:0] iram_rdata,
	output logic bit_rdata,
	output logic bit_illegal,
	// External data move requests
	input wire logic xmove_rd,
	input wire logic xmove_wr,
	input wire logic xmove_use_active_data_pointer,
	input wire logic [15:0] xmove_addr,
	input wire logic [7:0] xmove_wdata,
	output logic [7:0] xmove_rdata,
	output logic xmove_done,
	output logic [15:0] active_data_pointer,
	// External bus
	input wire logic [7:0] port0_in,
	output logic [7:0] port0_out,
	output logic [7:0] port0_oe,
	output logic [7:0] port2_out,
	output logic ext_ale,
	output logic ext_rd_n,
	output logic ext_wr_n,
	// Peripheral events and pins
	input wire logic timer0_overflow,
	input wire logic timer1_overflow,
	input wire logic timer0_vector_ack,
	input wire logic timer1_vector_ack,
	input wire logic ext_irq0_vector_ack,
	input wire logic ext_irq1_vector_ack,
	input wire logic ext_irq0_pin,
	input wire logic ext_irq1_pin,
	input wire logic wake_event,
	// Control outputs to peripherals and clocking
	output logic timer0_run,
	output logic timer1_run,
	output logic baud_doubler,
	output logic framing_error_select,
	output logic cpu_clock_stop,
	output logic all_clock_stop,
	output logic timer_irq_flags_valid,
	output logic [3:0] timer_irq_flags
);
	import csd_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] scratch [0:SCRATCH_DEPTH-1];
	logic [7:0] sram [0:SRAM_DEPTH-1];
	logic [7:0] port0_latch;
	logic [7:0] stack_top_pointer;
	logic [7:0] first_pointer_low;
	logic [7:0] first_pointer_high;
	logic [7:0] second_pointer_low;
	logic [7:0] second_pointer_high;
	logic pointer_select;
	logic [7:0] power_control;
	logic [7:0] timer_irq_control;
	logic onchip_sram_enable;
	logic [1:0] ext_pin_q;
	logic [7:0] sfr_read;
	logic [1:0] bus_phase;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Upper half by direct address is SFR space, by indirect is scratchpad
	wire is_sfr = iram_addr[7] & ~iram_indirect;
	wire bit_ok = (iram_addr[2:0] == 3'h0);
	wire sfr_wr = iram_wr & is_sfr & (~bit_op | bit_ok);
	wire scratch_wr = iram_wr & ~is_sfr & ~bit_op;

	// Merge a single bit into a byte for bit writes
	function automatic logic [7:0] merge_bit(input logic [7:0] cur,
		input logic [7:0] wd, input logic bop, input logic [2:0] sel,
		input logic bv);
		logic [7:0] r;
		r = cur;
		if (bop) begin
			r[sel] = bv;
		end else begin
			r = wd;
		end
		return r;
	endfunction : merge_bit

	// Register write value as seen from the core
	function automatic logic [7:0] wval(input logic [7:0] cur);
		return merge_bit(cur, iram_wdata, bit_op, bit_sel, bit_wval);
	endfunction : wval

	wire wr_p0 = sfr_wr & (iram_addr == ADDR_PORT0_LATCH);
	wire wr_sp = sfr_wr & (iram_addr == ADDR_STACK_TOP_POINTER);
	wire wr_dpl = sfr_wr & (iram_addr == ADDR_FIRST_POINTER_LOW);
	wire wr_dph = sfr_wr & (iram_addr == ADDR_FIRST_POINTER_HIGH);
	wire wr_second_pointer_low = sfr_wr & (iram_addr == ADDR_SECOND_POINTER_LOW);
	wire wr_second_pointer_high = sfr_wr & (iram_addr == ADDR_SECOND_POINTER_HIGH);
	wire wr_dps = sfr_wr & (iram_addr == ADDR_POINTER_SELECT);
	wire wr_power_control = sfr_wr & (iram_addr == ADDR_POWER_CONTROL);
	wire wr_timer_irq_control = sfr_wr & (iram_addr == ADDR_TIMER_IRQ_CONTROL);
	wire wr_mm = sfr_wr & (iram_addr == ADDR_MEM_MODE);

	// Selected pointer pair
	wire [15:0] next_active = pointer_select ?
		{second_pointer_high, second_pointer_low} :
		{first_pointer_high, first_pointer_low};

	// Routing of external data moves
	wire [15:0] move_addr = xmove_use_active_data_pointer ? next_active : xmove_addr;
	wire in_sram = onchip_sram_enable &
		(move_addr <= SRAM_LAST_ADDR);
	wire move_req = (xmove_rd | xmove_wr) & (bus_phase == 2'd0);
	wire go_sram = move_req & in_sram;
	wire go_ext = move_req & ~in_sram;

	// Control register with unimplemented bits forced to one
	wire [7:0] power_control_view = power_control | PC_UNUSED_MASK;

	// SFR read multiplexer
	always_comb begin
		unique case (iram_addr)
			ADDR_PORT0_LATCH: sfr_read = port0_in;
			ADDR_STACK_TOP_POINTER: sfr_read = stack_top_pointer;
			ADDR_FIRST_POINTER_LOW: sfr_read = first_pointer_low;
			ADDR_FIRST_POINTER_HIGH: sfr_read = first_pointer_high;
			ADDR_SECOND_POINTER_LOW: sfr_read = second_pointer_low;
			ADDR_SECOND_POINTER_HIGH: sfr_read = second_pointer_high;
			ADDR_POINTER_SELECT: sfr_read = {7'h00, pointer_select};
			ADDR_POWER_CONTROL: sfr_read = power_control_view;
			ADDR_TIMER_IRQ_CONTROL: sfr_read = timer_irq_control;
			ADDR_MEM_MODE: sfr_read = {7'h7f, onchip_sram_enable};
			default: sfr_read = UNIMPL_READ;
		endcase
	end

	wire [7:0] rd_byte = is_sfr ? sfr_read : scratch[iram_addr];

	// ----------------------------------------
	// Core read port
	// ----------------------------------------
	// Registered read data, bit result and illegal bit access flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			iram_rdata <= RST_ZERO;
			bit_rdata <= 1'b0;
			bit_illegal <= 1'b0;
		end else begin
			iram_rdata <= iram_rd ? rd_byte : iram_rdata;
			bit_rdata <= rd_byte[bit_sel];
			bit_illegal <= bit_op & (iram_rd | iram_wr) & is_sfr &
				~bit_ok;
		end
	end

	// Scratchpad writes, reached directly below 80h or indirectly anywhere
	always_ff @(posedge clk) begin
		if (scratch_wr) begin
			scratch[iram_addr] <= iram_wdata;
		end
	end

	// ----------------------------------------
	// Pointer and stack registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stack_top_pointer <= RST_STACK;
			first_pointer_low <= RST_ZERO;
			first_pointer_high <= RST_ZERO;
			second_pointer_low <= RST_ZERO;
			second_pointer_high <= RST_ZERO;
			pointer_select <= 1'b0;
		end else begin
			if (wr_sp) stack_top_pointer <= wval(stack_top_pointer);
			if (wr_dpl) first_pointer_low <= iram_wdata;
			if (wr_dph) first_pointer_high <= iram_wdata;
			if (wr_second_pointer_low) second_pointer_low <= iram_wdata;
			if (wr_second_pointer_high) second_pointer_high <= iram_wdata;
			if (wr_dps) pointer_select <= iram_wdata[0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_data_pointer <= 16'h0000;
		end else begin
			active_data_pointer <= next_active;
		end
	end

	// ----------------------------------------
	// Power control and memory mode
	// ----------------------------------------
	// Sleep requests clear on a wake event unless the register is written in that cycle; user flags have no effect
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_control <= RST_ZERO;
			onchip_sram_enable <= 1'b0;
		end else begin
			if (wr_power_control) begin
				power_control <= wval(power_control_view) & ~PC_UNUSED_MASK;
			end else if (wake_event) begin
				power_control[PC_POWER_DOWN] <= 1'b0;
				power_control[PC_IDLE] <= 1'b0;
			end
			if (wr_mm) onchip_sram_enable <= iram_wdata[MM_SRAM_ENABLE];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_doubler <= 1'b0;
			framing_error_select <= 1'b0;
			cpu_clock_stop <= 1'b0;
			all_clock_stop <= 1'b0;
		end else begin
			baud_doubler <= power_control[PC_BAUD_DOUBLER];
			framing_error_select <= power_control[PC_FE_SELECT];
			all_clock_stop <= power_control[PC_POWER_DOWN];
			cpu_clock_stop <= power_control[PC_IDLE] |
				power_control[PC_POWER_DOWN];
		end
	end

	// ----------------------------------------
	// Timer and external interrupt control
	// ----------------------------------------
	// Previous pin levels for falling-edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_pin_q <= 2'b11;
		end else begin
			ext_pin_q <= {ext_irq1_pin, ext_irq0_pin};
		end
	end

	wire [1:0] ext_fall = ext_pin_q & ~{ext_irq1_pin, ext_irq0_pin};
	wire [7:0] tc_sw = wval(timer_irq_control);
	wire [7:0] tc_base = wr_timer_irq_control ? tc_sw : timer_irq_control;
	logic [7:0] next_timer_irq_control;

	// Hardware set wins over software or acknowledge clear
	always_comb begin
		next_timer_irq_control = tc_base;
		if (timer1_vector_ack) next_timer_irq_control[TC_TF1] = 1'b0;
		if (timer0_vector_ack) next_timer_irq_control[TC_TF0] = 1'b0;
		if (timer1_overflow) next_timer_irq_control[TC_TF1] = 1'b1;
		if (timer0_overflow) next_timer_irq_control[TC_TF0] = 1'b1;
		if (tc_base[TC_IT1]) begin
			if (ext_irq1_vector_ack) next_timer_irq_control[TC_IE1] = 1'b0;
			if (ext_fall[1]) next_timer_irq_control[TC_IE1] = 1'b1;
		end else begin
			next_timer_irq_control[TC_IE1] = ~ext_irq1_pin;
		end
		if (tc_base[TC_IT0]) begin
			if (ext_irq0_vector_ack) next_timer_irq_control[TC_IE0] = 1'b0;
			if (ext_fall[0]) next_timer_irq_control[TC_IE0] = 1'b1;
		end else begin
			next_timer_irq_control[TC_IE0] = ~ext_irq0_pin;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_irq_control <= RST_ZERO;
			timer0_run <= 1'b0;
			timer1_run <= 1'b0;
			timer_irq_flags <= 4'h0;
			timer_irq_flags_valid <= 1'b0;
		end else begin
			timer_irq_control <= next_timer_irq_control;
			timer1_run <= next_timer_irq_control[TC_TR1];
			timer0_run <= next_timer_irq_control[TC_TR0];
			timer_irq_flags <= {next_timer_irq_control[TC_TF1], next_timer_irq_control[TC_TF0],
				next_timer_irq_control[TC_IE1], next_timer_irq_control[TC_IE0]};
			timer_irq_flags_valid <= 1'b1;
		end
	end

	// ----------------------------------------
	// On-chip data SRAM
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (go_sram & xmove_wr) begin
			sram[move_addr[9:0]] <= xmove_wdata;
		end
	end

	// ----------------------------------------
	// External bus sequencer and port 0
	// ----------------------------------------
	// Phase 1 drives address with ALE, phase 2 strobes, phase 3 finishes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_phase <= 2'd0;
			port0_latch <= RST_PORT0_LATCH;
			port0_out <= RST_ZERO;
			port0_oe <= RST_ZERO;
			port2_out <= RST_ZERO;
			ext_ale <= 1'b0;
			ext_rd_n <= 1'b1;
			ext_wr_n <= 1'b1;
			xmove_rdata <= RST_ZERO;
			xmove_done <= 1'b0;
		end else begin
			xmove_done <= 1'b0;
			if (wr_p0) port0_latch <= wval(port0_latch);
			unique case (bus_phase)
				2'd0: begin
					// Open drain: drive only zeros of the latch
					port0_out <= RST_ZERO;
					port0_oe <= ~port0_latch;
					if (go_sram) begin
						xmove_rdata <= sram[move_addr[9:0]];
						xmove_done <= 1'b1;
					end else if (go_ext) begin
						port0_out <= move_addr[7:0];
						port0_oe <= 8'hff;
						port2_out <= move_addr[15:8];
						ext_ale <= 1'b1;
						bus_phase <= 2'd1;
					end
				end
				2'd1: begin
					ext_ale <= 1'b0;
					port0_out <= xmove_wdata;
					port0_oe <= xmove_wr ? 8'hff : 8'h00;
					ext_rd_n <= ~xmove_rd;
					ext_wr_n <= ~xmove_wr;
					bus_phase <= 2'd2;
				end
				2'd2: begin
					xmove_rdata <= port0_in;
					ext_rd_n <= 1'b1;
					ext_wr_n <= 1'b1;
					xmove_done <= 1'b1;
					bus_phase <= 2'd3;
				end
				2'd3: begin
					port0_oe <= RST_ZERO;
					bus_phase <= 2'd0;
				end
			endcase
		end
	end
endmodule : csd_core_sfr

// File: hdl/csd_pkg.sv
// Package: SFR map, field positions, reset values and sizes for the core SFR bank
package csd_pkg;
	// ----------------------------------------
	// SFR direct addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
	localparam logic [7:0] ADDR_STACK_TOP_POINTER = 8'h81;
	localparam logic [7:0] ADDR_FIRST_POINTER_LOW = 8'h82;
	localparam logic [7:0] ADDR_FIRST_POINTER_HIGH = 8'h83;
	localparam logic [7:0] ADDR_SECOND_POINTER_LOW = 8'h84;
	localparam logic [7:0] ADDR_SECOND_POINTER_HIGH = 8'h85;
	localparam logic [7:0] ADDR_POINTER_SELECT = 8'h86;
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_TIMER_IRQ_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_MEM_MODE = 8'hc4;
	localparam logic [7:0] SFR_BASE = 8'h80;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PC_BAUD_DOUBLER = 7;
	localparam int PC_FE_SELECT = 6;
	localparam int PC_USER_HIGH = 3;
	localparam int PC_USER_LOW = 2;
	localparam int PC_POWER_DOWN = 1;
	localparam int PC_IDLE = 0;
	localparam int TC_TF1 = 7;
	localparam int TC_TR1 = 6;
	localparam int TC_TF0 = 5;
	localparam int TC_TR0 = 4;
	localparam int TC_IE1 = 3;
	localparam int TC_IT1 = 2;
	localparam int TC_IE0 = 1;
	localparam int TC_IT0 = 0;
	localparam int MM_SRAM_ENABLE = 0;
	// ----------------------------------------
	// Reset values and sizes
	// ----------------------------------------
	localparam logic [7:0] RST_PORT0_LATCH = 8'hff;
	localparam logic [7:0] RST_STACK = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] UNIMPL_READ = 8'hff;
	localparam logic [7:0] PC_UNUSED_MASK = 8'h30;
	localparam logic [15:0] SRAM_LAST_ADDR = 16'h03ff;
	localparam int SRAM_DEPTH = 1024;
	localparam int SCRATCH_DEPTH = 256;
endpackage : csd_pkg

// File: verification/csd_core_sfr_bench.sv
// Self-checking bench of the core SFR bank
`timescale 1ns/1ps
module csd_core_sfr_bench;
	import csd_pkg::*;
	logic clk = 1'b0;
	logic rst_n, iram_rd, iram_wr, iram_indirect, bit_op, bit_wval;
	logic [7:0] iram_addr, iram_wdata, iram_rdata, xmove_wdata, xmove_rdata;
	logic [2:0] bit_sel;
	logic xmove_rd, xmove_wr, xmove_use_active_data_pointer, xmove_done, bit_rdata;
	logic [15:0] xmove_addr, active_data_pointer;
	logic [7:0] port0_in, port0_out, port0_oe, port2_out;
	logic ext_ale, ext_rd_n, ext_wr_n, bit_illegal, wake_event;
	logic timer0_overflow, timer1_overflow, timer0_vector_ack;
	logic timer1_vector_ack, ext_irq0_vector_ack, ext_irq1_vector_ack;
	logic ext_irq0_pin, ext_irq1_pin, timer0_run, timer1_run, baud_doubler;
	logic framing_error_select, cpu_clock_stop, all_clock_stop;
	logic timer_irq_flags_valid;
	logic [3:0] timer_irq_flags;
	logic [31:0] s = 32'h3aeb5a6f;
	logic [15:0] a;
	logic [7:0] sp_val;
	int fails = 0;
	int checked = 0;
	logic [7:0] ra [9] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
		8'h88, 8'hc4};
	logic [7:0] rv [9] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30,
		8'h00, 8'hfe};
	csd_core_sfr uut (.clk, .rst_n, .iram_rd, .iram_wr, .iram_indirect,
		.iram_addr, .iram_wdata, .bit_op, .bit_sel, .bit_wval, .iram_rdata,
		.bit_rdata, .bit_illegal, .xmove_rd, .xmove_wr, .xmove_use_active_data_pointer,
		.xmove_addr, .xmove_wdata, .xmove_rdata, .xmove_done,
		.active_data_pointer, .port0_in, .port0_out, .port0_oe, .port2_out,
		.ext_ale, .ext_rd_n, .ext_wr_n, .timer0_overflow, .timer1_overflow,
		.timer0_vector_ack, .timer1_vector_ack, .ext_irq0_vector_ack,
		.ext_irq1_vector_ack, .ext_irq0_pin, .ext_irq1_pin, .wake_event,
		.timer0_run, .timer1_run, .baud_doubler, .framing_error_select,
		.cpu_clock_stop, .all_clock_stop, .timer_irq_flags_valid,
		.timer_irq_flags);
	csd_ext_mem_model mem_model (.clk, .port0_out, .port0_oe, .port2_out,
		.ext_ale, .ext_rd_n, .ext_wr_n, .port0_in);
	// Clock
	always #2 clk = ~clk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// One RAM/SFR cycle; m = {bit op, indirect}, bit number d[2:0], value d[3]
	task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d,
		input logic [1:0] m);
		@(negedge clk);
		{iram_rd, iram_wr, bit_op, iram_indirect} = {!w, w, m};
		{iram_addr, iram_wdata, bit_sel, bit_wval} = {ad, d, d[2:0], d[3]};
		@(negedge clk);
		{iram_rd, iram_wr} = 2'b00;
	endtask : acc
	task automatic rd(input logic [7:0] ad, input logic [1:0] m,
		input logic [7:0] e);
		acc(1'b0, ad, 8'h00, m);
		chk(iram_rdata, e);
	endtask : rd
	task automatic pls(ref logic p);
		@(negedge clk);
		p = 1'b1;
		@(negedge clk);
		p = 1'b0;
		@(negedge clk);
	endtask : pls
	// Data move held until done; ext tells whether the bus must be used
	task automatic mv(input logic w, input logic [15:0] ad, input logic [7:0] d,
		input logic ext, input logic [7:0] e);
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		@(negedge clk);
		{xmove_rd, xmove_wr, xmove_addr, xmove_wdata} = {!w, w, ad, d};
		while (xmove_done !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			seen = seen | ext_ale;
			n++;
		end
		if (n >= 20) begin
			fails++;
			summarize();
		end
		@(negedge clk);
		{xmove_rd, xmove_wr} = 2'b00;
		chk(seen, ext);
		if (!w) chk(xmove_rdata, e);
	endtask : mv
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_n, iram_rd, iram_wr, iram_indirect, bit_op, bit_wval} = '0;
		{iram_addr, iram_wdata, bit_sel, xmove_addr, xmove_wdata} = '0;
		{xmove_rd, xmove_wr, xmove_use_active_data_pointer, wake_event} = '0;
		{timer0_overflow, timer1_overflow, timer0_vector_ack} = '0;
		{timer1_vector_ack, ext_irq0_vector_ack, ext_irq1_vector_ack} = '0;
		{ext_irq0_pin, ext_irq1_pin} = 2'b11;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 9; i++) rd(ra[i], 2'b00, rv[i]);
		chk(timer_irq_flags_valid, 1'b1);
		for (int i = 0; i < 5; i++) begin
			s = lfsr(s);
			// Last two bytes written form the second pointer pair
			a = {s[7:0], a[15:8]};
			if (i == 0) sp_val = s[7:0];
			acc(1'b1, 8'(8'h81 + i), s[7:0], 2'b00);
			rd(8'(8'h81 + i), 2'b00, s[7:0]);
		end
		acc(1'b1, ADDR_POINTER_SELECT, 8'hff, 2'b00);
		rd(ADDR_POINTER_SELECT, 2'b00, 8'h01);
		chk(active_data_pointer, a);
		$display("storage test done");
		for (int i = 0; i < 3; i++) rd(8'h89 + 8'(i * 7), 2'b00, 8'hff);
		acc(1'b1, ADDR_POWER_CONTROL, 8'hcc, 2'b00);
		rd(ADDR_POWER_CONTROL, 2'b00, 8'hfc);
		chk({baud_doubler, framing_error_select}, 2'b11);
		acc(1'b1, ADDR_POWER_CONTROL, 8'h01, 2'b00);
		// Clock stop outputs follow the register one edge later
		@(negedge clk);
		chk({cpu_clock_stop, all_clock_stop}, 2'b10);
		pls(wake_event);
		acc(1'b1, ADDR_POWER_CONTROL, 8'h02, 2'b00);
		@(negedge clk);
		chk({cpu_clock_stop, all_clock_stop, baud_doubler}, 3'b110);
		pls(wake_event);
		chk(cpu_clock_stop, 1'b0);
		acc(1'b1, 8'h90, 8'ha5, 2'b01);
		rd(8'h90, 2'b01, 8'ha5);
		rd(8'h90, 2'b00, 8'hff);
		$display("control test done");
		acc(1'b1, ADDR_TIMER_IRQ_CONTROL, 8'h0c, 2'b10);
		chk(timer0_run, 1'b1);
		acc(1'b1, ADDR_STACK_TOP_POINTER, 8'h08, 2'b10);
		chk(bit_illegal, 1'b1);
		rd(ADDR_STACK_TOP_POINTER, 2'b00, sp_val);
		pls(timer0_overflow);
		rd(ADDR_TIMER_IRQ_CONTROL, 2'b00, 8'h30);
		// Bit read of the timer 0 overflow flag
		acc(1'b0, ADDR_TIMER_IRQ_CONTROL, 8'h05, 2'b10);
		chk(bit_rdata, 1'b1);
		pls(timer0_vector_ack);
		chk(timer_irq_flags[2], 1'b0);
		acc(1'b1, ADDR_TIMER_IRQ_CONTROL, 8'h80, 2'b00);
		chk({timer_irq_flags[3], timer0_run}, 2'b10);
		pls(timer1_vector_ack);
		{ext_irq0_pin, ext_irq1_pin} = 2'b00;
		repeat (3) @(negedge clk);
		chk(timer_irq_flags, 4'h3);
		{ext_irq0_pin, ext_irq1_pin} = 2'b11;
		repeat (3) @(negedge clk);
		chk(timer_irq_flags, 4'h0);
		acc(1'b1, ADDR_TIMER_IRQ_CONTROL, 8'h05, 2'b00);
		{ext_irq0_pin, ext_irq1_pin} = 2'b00;
		repeat (3) @(negedge clk);
		{ext_irq0_pin, ext_irq1_pin} = 2'b11;
		repeat (3) @(negedge clk);
		chk(timer_irq_flags, 4'h3);
		pls(ext_irq0_vector_ack);
		pls(ext_irq1_vector_ack);
		chk(timer_irq_flags, 4'h0);
		$display("flag test done");
		mv(1'b1, 16'h0010, 8'h3c, 1'b1, 8'h00);
		mv(1'b0, 16'h0010, 8'h00, 1'b1, 8'h3c);
		acc(1'b1, ADDR_MEM_MODE, 8'h01, 2'b00);
		mv(1'b1, SRAM_LAST_ADDR, 8'hc3, 1'b0, 8'h00);
		mv(1'b0, SRAM_LAST_ADDR, 8'h00, 1'b0, 8'hc3);
		mv(1'b0, 16'h0400, 8'h00, 1'b1, 8'h04);
		for (int i = 0; i < 4; i++) begin
			s = lfsr(s);
			a = s[15:0] | 16'h0400;
			mv(1'b1, a, s[23:16], 1'b1, 8'h00);
			mv(1'b0, a, 8'h00, 1'b1, s[23:16]);
			mv(1'b1, {6'h00, s[9:0]}, s[31:24], 1'b0, 8'h00);
			mv(1'b0, {6'h00, s[9:0]}, 8'h00, 1'b0, s[31:24]);
		end
		acc(1'b1, ADDR_SECOND_POINTER_LOW, 8'h34, 2'b00);
		acc(1'b1, ADDR_SECOND_POINTER_HIGH, 8'h12, 2'b00);
		xmove_use_active_data_pointer = 1'b1;
		mv(1'b1, 16'h0000, 8'h99, 1'b1, 8'h00);
		xmove_use_active_data_pointer = 1'b0;
		mv(1'b0, 16'h1234, 8'h00, 1'b1, 8'h99);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd(ADDR_MEM_MODE, 2'b00, 8'hfe);
		mv(1'b0, SRAM_LAST_ADDR, 8'h00, 1'b1, 8'hfc);
		$display("move test done");
		summarize();
	end
endmodule : csd_core_sfr_bench

// File: verification/csd_core_sfr_monitor.sv
// Checker on the ports of the core SFR bank
`timescale 1ns/1ps
module csd_core_sfr_monitor
	import csd_pkg::*;
(
	input logic clk,
	input logic rst_n,
	input logic iram_rd,
	input logic iram_wr,
	input logic iram_indirect,
	input logic bit_op,
	input logic [7:0] iram_addr,
	input logic [7:0] iram_wdata,
	input logic [7:0] iram_rdata,
	input logic bit_illegal,
	input logic xmove_done,
	input logic [7:0] port0_oe,
	input logic ext_ale,
	input logic ext_rd_n,
	input logic ext_wr_n,
	input logic timer0_overflow,
	input logic timer0_vector_ack,
	input logic wake_event,
	input logic timer0_run,
	input logic timer1_run,
	input logic baud_doubler,
	input logic cpu_clock_stop,
	input logic all_clock_stop,
	input logic [3:0] timer_irq_flags
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Decodes and bus phases
	// ----------------------------------------
	wire sfr_wr = iram_wr && !iram_indirect && !bit_op;
	wire byte_rd = iram_rd && !iram_indirect && !bit_op;
	wire pc_wr = sfr_wr && iram_addr == ADDR_POWER_CONTROL;
	sequence addr_phase;
		ext_ale && port0_oe == 8'hff;
	endsequence
	sequence strobe_phase;
		!ext_ale && !(ext_rd_n && ext_wr_n);
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	bus_phase_a: assert property ($rose(ext_ale) |-> addr_phase ##1 strobe_phase)
		else $error("address phase not followed by strobe");
	strobe_end_a: assert property ($fell(ext_rd_n) || $fell(ext_wr_n) |=>
		ext_rd_n && ext_wr_n && xmove_done) else $error("strobe not one cycle");
	bit_refuse_a: assert property ((iram_rd || iram_wr) && bit_op &&
		!iram_indirect && iram_addr[7] && iram_addr[2:0] != 3'h0 |=> bit_illegal)
		else $error("bit access not refused");
	bit_cause_a: assert property (bit_illegal |->
		$past(bit_op && iram_addr[2:0] != 3'h0)) else $error("spurious refusal");
	unimpl_read_a: assert property (byte_rd && iram_addr == 8'h90 |=>
		iram_rdata == UNIMPL_READ) else $error("empty place not ones");
	select_zero_a: assert property (byte_rd && iram_addr == ADDR_POINTER_SELECT
		|=> iram_rdata[7:1] == 7'h00) else $error("select upper bits set");
	run_ctrl_a: assert property (sfr_wr && iram_addr == ADDR_TIMER_IRQ_CONTROL |=>
		timer0_run == $past(iram_wdata[TC_TR0]) &&
		timer1_run == $past(iram_wdata[TC_TR1])) else $error("run bits wrong");
	// Control outputs are registered from the register, two edges after a write
	baud_ctrl_a: assert property (pc_wr |=> ##1
		baud_doubler == $past(iram_wdata[PC_BAUD_DOUBLER], 2))
		else $error("baud bit");
	idle_stop_a: assert property (pc_wr && iram_wdata[PC_IDLE] &&
		!wake_event |=> ##1 cpu_clock_stop)
		else $error("idle did not stop cpu clock");
	pd_stop_a: assert property (pc_wr && iram_wdata[PC_POWER_DOWN] &&
		!wake_event |=> ##1 all_clock_stop && cpu_clock_stop)
		else $error("power-down failed");
	tf_set_a: assert property (timer0_overflow |=> timer_irq_flags[2])
		else $error("overflow flag not set");
	tf_ack_a: assert property (timer0_vector_ack && !timer0_overflow && !iram_wr
		|=> !timer_irq_flags[2]) else $error("ack did not clear flag");
endmodule : csd_core_sfr_monitor

bind csd_core_sfr csd_core_sfr_monitor mon (.clk, .rst_n, .iram_rd, .iram_wr,
	.iram_indirect, .bit_op, .iram_addr, .iram_wdata, .iram_rdata, .bit_illegal,
	.xmove_done, .port0_oe, .ext_ale, .ext_rd_n, .ext_wr_n, .timer0_overflow,
	.timer0_vector_ack, .wake_event, .timer0_run, .timer1_run, .baud_doubler,
	.cpu_clock_stop, .all_clock_stop, .timer_irq_flags);

// File: verification/csd_ext_mem_model.sv
// External data memory on the multiplexed port 0 / port 2 bus
`timescale 1ns/1ps
module csd_ext_mem_model (
	input logic clk,
	input logic [7:0] port0_out,
	input logic [7:0] port0_oe,
	input logic [7:0] port2_out,
	input logic ext_ale,
	input logic ext_rd_n,
	input logic ext_wr_n,
	output logic [7:0] port0_in
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr = 16'h0000;
	logic [7:0] last = 8'h00;
	// Unwritten places hold a pattern made from their address
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'(i >> 8);
		end
	end
	// Address latch while ALE is high, write capture while strobe is low
	always @(posedge clk) begin
		if (ext_ale) begin
			addr <= {port2_out, port0_out};
		end
		if (!ext_wr_n) begin
			mem[addr] <= port0_in;
		end
		last <= port0_in;
	end
	// Open-drain wire: design drive, memory drive, else a floating pattern
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			port0_in[i] = port0_oe[i] ? port0_out[i] :
				(!ext_rd_n ? mem[addr][i] : ~last[i]);
		end
	end
endmodule : csd_ext_mem_model
